// ---- src/ecppr_pkg.sv ----
// package: offsets, fields, modes and carriers of the parallel port register bank
package ecppr_pkg;
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_INFO_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  localparam logic [7:0] INFO_A_VALUE = 8'h10;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [2:0] EXT_MODE_RESET = 3'h0;
  localparam int EXT_MODE_LSB = 5;
  localparam int EXT_DMA_BIT = 3;
  localparam int EXT_SERVICE_BIT = 2;
  localparam int EXT_FULL_BIT = 1;
  localparam int EXT_EMPTY_BIT = 0;
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFEED = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELECT = 3;
  localparam int CTL_ACK_IRQ = 4;
  localparam int CTL_DIRECTION = 5;
  localparam int INFO_B_IRQ_BIT = 6;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] TX_SPACE_THRESHOLD = 5'h08;
  localparam logic [4:0] RX_FILL_THRESHOLD = 5'h08;
  localparam int HS_STROBE_CYCLES = 2;
  typedef enum logic [2:0] {
    ECPPR_MODE_STANDARD = 3'h0,
    ECPPR_MODE_BIDIR = 3'h1,
    ECPPR_MODE_FIFO = 3'h2,
    ECPPR_MODE_ECP = 3'h3,
    ECPPR_MODE_EPP = 3'h4,
    ECPPR_MODE_RSVD = 3'h5,
    ECPPR_MODE_TEST = 3'h6,
    ECPPR_MODE_CONFIG = 3'h7
  } ecppr_mode_t;
  typedef struct packed {
    logic tag;
    logic [7:0] data;
  } ecppr_entry_t;
endpackage : ecppr_pkg

// ---- src/ecppr_top.sv ----
// top: mode-dependent register bank, shared fifo and automatic cable transfer
`timescale 1ns/1ps
`default_nettype none
module ecppr_top #(
  parameter int DEPTH = ecppr_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic [10:0] ADDR_IN,
  input wire logic AEN_IN,
  input wire logic IO_READ_STROBE_N_IN,
  input wire logic IO_WRITE_STROBE_N_IN,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_N_OUT,
  input wire logic [7:0] CABLE_DATA_LINES_IN,
  output logic [7:0] CABLE_DATA_LINES_OUT,
  output logic CABLE_DATA_LINES_OE_N_OUT,
  input wire logic FAULT_IN_N_IN,
  input wire logic SELECT_IN,
  input wire logic PAPER_ERROR_IN_IN,
  input wire logic ACKNOWLEDGE_IN_N_IN,
  input wire logic BUSY_IN,
  input wire logic EPP_ENABLED_IN,
  output logic STROBE_OUT_N_OUT,
  output logic AUTOFEED_OUT_N_OUT,
  output logic INITIALIZE_OUT_N_OUT,
  output logic SELECT_IN_OUT_N_OUT,
  output logic IRQ_OUT,
  output logic ECP_MODE_OUT
);
  localparam int PW = $clog2(DEPTH);
  // reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // pin synchronisers: three stages, change counts when stages two and three agree
  // cable data has its own synchroniser below
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [NPIN-1:0] pin_s3_reg;
  logic [NPIN-1:0] pin_reg;
  assign pin_raw = {IO_READ_STROBE_N_IN, IO_WRITE_STROBE_N_IN, FAULT_IN_N_IN, SELECT_IN,
                    PAPER_ERROR_IN_IN, ACKNOWLEDGE_IN_N_IN, BUSY_IN};
  logic [7:0] cab_s1_reg;
  logic [7:0] cab_s2_reg;
  logic [7:0] cab_s3_reg;
  logic [7:0] cab_reg;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      pin_s3_reg <= '1;
      pin_reg <= '1;
      cab_s1_reg <= 8'h00;
      cab_s2_reg <= 8'h00;
      cab_s3_reg <= 8'h00;
      cab_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < NPIN; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
      cab_s1_reg <= CABLE_DATA_LINES_IN;
      cab_s2_reg <= cab_s1_reg;
      cab_s3_reg <= cab_s2_reg;
      for (int i = 0; i < 8; i++) begin
        if (cab_s2_reg[i] == cab_s3_reg[i]) begin
          cab_reg[i] <= cab_s3_reg[i];
        end
      end
    end
  end
  logic ior_n, iow_n, fault_n, sel, perr, ack_n, busy;
  assign ior_n = pin_reg[6];
  assign iow_n = pin_reg[5];
  assign fault_n = pin_reg[4];
  assign sel = pin_reg[3];
  assign perr = pin_reg[2];
  assign ack_n = pin_reg[1];
  assign busy = pin_reg[0];

  // bus strobes: address and data sampled every cycle a synchronised strobe is low; reads decode the live address
  logic iow_d_reg, ior_d_reg;
  logic [10:0] addr_reg;
  logic [7:0] wdata_reg;
  logic aen_reg;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      iow_d_reg <= 1'b1;
      ior_d_reg <= 1'b1;
      addr_reg <= 11'h000;
      wdata_reg <= 8'h00;
      aen_reg <= 1'b1;
    end else begin
      iow_d_reg <= iow_n;
      ior_d_reg <= ior_n;
      if (!iow_n || !ior_n) begin
        addr_reg <= ADDR_IN;
        wdata_reg <= HOST_DATA_IN;
        aen_reg <= AEN_IN;
      end
    end
  end
  logic wr_pulse, rd_start;
  assign wr_pulse = iow_n && !iow_d_reg && !aen_reg;
  assign rd_start = !ior_n && ior_d_reg && !AEN_IN;

  function automatic logic hit(input logic [10:0] a, input logic [10:0] ofs, input logic en);
    hit = (a == ofs) && en;
  endfunction : hit

  // registers
  logic [7:0] data_reg;
  logic [5:0] ctl_reg;
  logic [2:0] mode_reg;
  logic dma_reg;
  logic service_reg;
  ecppr_pkg::ecppr_mode_t mode;
  assign mode = ecppr_pkg::ecppr_mode_t'(mode_reg);
  logic direction_in;
  assign direction_in = ctl_reg[ecppr_pkg::CTL_DIRECTION] &&
      !(mode == ecppr_pkg::ECPPR_MODE_STANDARD || mode == ecppr_pkg::ECPPR_MODE_FIFO);

  logic wr_data, wr_ctl, wr_ext, wr_fifo, wr_addr;
  assign wr_data = wr_pulse && hit(addr_reg, ecppr_pkg::OFS_DATA,
      mode == ecppr_pkg::ECPPR_MODE_STANDARD || mode == ecppr_pkg::ECPPR_MODE_BIDIR);
  assign wr_addr = wr_pulse && hit(addr_reg, ecppr_pkg::OFS_DATA,
      mode == ecppr_pkg::ECPPR_MODE_ECP && !direction_in);
  assign wr_ctl = wr_pulse && hit(addr_reg, ecppr_pkg::OFS_CONTROL, 1'b1);
  assign wr_ext = wr_pulse && hit(addr_reg, ecppr_pkg::OFS_EXT_CTRL, 1'b1);
  assign wr_fifo = wr_pulse && hit(addr_reg, ecppr_pkg::OFS_FIFO,
      mode == ecppr_pkg::ECPPR_MODE_FIFO || mode == ecppr_pkg::ECPPR_MODE_ECP ||
      mode == ecppr_pkg::ECPPR_MODE_TEST);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= ecppr_pkg::DATA_RESET;
    end else if (wr_data) begin
      data_reg <= wdata_reg;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= ecppr_pkg::CONTROL_RESET;
    end else if (wr_ctl) begin
      ctl_reg <= wdata_reg[5:0];
    end
  end
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= ecppr_pkg::EXT_MODE_RESET;
      dma_reg <= 1'b0;
    end else if (wr_ext) begin
      mode_reg <= wdata_reg[ecppr_pkg::EXT_MODE_LSB +: 3];
      dma_reg <= wdata_reg[ecppr_pkg::EXT_DMA_BIT];
    end
  end

  // shared fifo with tag bit
  ecppr_pkg::ecppr_entry_t mem [DEPTH];
  logic [PW-1:0] wp_reg, rp_reg;
  logic [PW:0] cnt_reg;
  logic full, empty;
  logic [7:0] last_rd_reg;
  assign full = cnt_reg == (PW+1)'(DEPTH);
  assign empty = cnt_reg == '0;
  logic push, pop, rd_fifo, cap_push, tx_pop;
  ecppr_pkg::ecppr_entry_t push_entry;
  logic fifo_mode;
  assign fifo_mode = mode == ecppr_pkg::ECPPR_MODE_FIFO || mode == ecppr_pkg::ECPPR_MODE_ECP ||
                     mode == ecppr_pkg::ECPPR_MODE_TEST;
  assign rd_fifo = rd_start && hit(ADDR_IN, ecppr_pkg::OFS_FIFO, fifo_mode);
  // host writes take priority; a capture on the same cycle is lost
  assign push = ((wr_fifo || wr_addr) && !full) || (cap_push && !full);
  assign push_entry.tag = wr_addr;
  assign push_entry.data = (wr_fifo || wr_addr) ? wdata_reg : cab_reg;
  assign pop = (rd_fifo || tx_pop) && !empty;
  always_ff @(posedge CLOCK_IN) begin
    if (push) begin
      mem[wp_reg] <= push_entry;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      last_rd_reg <= 8'h00;
    end else if (!fifo_mode) begin
      // leaving the fifo modes discards any leftover bytes
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= PW'(wp_reg + 1'b1);
      end
      if (pop) begin
        rp_reg <= PW'(rp_reg + 1'b1);
        last_rd_reg <= mem[rp_reg].data;
      end
      cnt_reg <= (PW+1)'(cnt_reg + push - pop);
    end
  end

  // two-entry output buffer between fifo head and cable sequencer
  ecppr_pkg::ecppr_entry_t ob_q [2];
  logic [1:0] ob_cnt_reg;
  logic ob_valid, ob_ready, ob_in_ready, ob_take;
  logic fwd_mode;
  assign fwd_mode = (mode == ecppr_pkg::ECPPR_MODE_FIFO ||
                     mode == ecppr_pkg::ECPPR_MODE_ECP) && !direction_in;
  assign ob_in_ready = ob_cnt_reg != 2'h2;
  assign tx_pop = fwd_mode && ob_in_ready && !rd_fifo;
  assign ob_valid = ob_cnt_reg != 2'h0;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ob_cnt_reg <= 2'h0;
      ob_q[0] <= '0;
      ob_q[1] <= '0;
    end else if (!fwd_mode) begin
      ob_cnt_reg <= 2'h0;
    end else begin
      if (ob_take) begin
        ob_q[0] <= ob_q[1];
      end
      if (tx_pop && !empty) begin
        if (ob_cnt_reg == 2'h0 || (ob_cnt_reg == 2'h1 && ob_take)) begin
          ob_q[0] <= mem[rp_reg];
        end else begin
          ob_q[1] <= mem[rp_reg];
        end
      end
      ob_cnt_reg <= 2'(ob_cnt_reg + (tx_pop && !empty) - ob_take);
    end
  end

  // cable sequencer: forward handshake and ecp reverse capture
  typedef enum logic [1:0] {
    ECPPR_IDLE = 2'b00,
    ECPPR_SETUP = 2'b01,
    ECPPR_STROBE = 2'b11,
    ECPPR_WAIT = 2'b10
  } ecppr_seq_t;
  ecppr_seq_t seq_reg;
  logic [7:0] tx_data_reg;
  logic tx_tag_reg;
  logic [1:0] hs_cnt_reg;
  logic hs_strobe_reg, hs_hostack_reg;
  assign ob_ready = seq_reg == ECPPR_IDLE && !busy;
  assign ob_take = ob_valid && ob_ready;
  assign cap_push = mode == ecppr_pkg::ECPPR_MODE_ECP && direction_in &&
                    seq_reg == ECPPR_SETUP;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= ECPPR_IDLE;
      tx_data_reg <= 8'h00;
      tx_tag_reg <= 1'b0;
      hs_cnt_reg <= 2'h0;
      hs_strobe_reg <= 1'b0;
      hs_hostack_reg <= 1'b0;
    end else if (mode == ecppr_pkg::ECPPR_MODE_ECP && direction_in) begin
      // reverse: hostack asserted while ready, byte latched when ack falls
      hs_strobe_reg <= 1'b0;
      unique case (seq_reg)
        ECPPR_IDLE: begin
          hs_hostack_reg <= !full;
          if (!full && !ack_n) begin
            seq_reg <= ECPPR_SETUP;
          end
        end
        ECPPR_SETUP: begin
          hs_hostack_reg <= 1'b0;
          seq_reg <= ECPPR_WAIT;
        end
        ECPPR_WAIT: begin
          if (ack_n) begin
            seq_reg <= ECPPR_IDLE;
          end
        end
        ECPPR_STROBE: begin
          seq_reg <= ECPPR_IDLE;
        end
      endcase
    end else if (!fwd_mode) begin
      seq_reg <= ECPPR_IDLE;
      hs_strobe_reg <= 1'b0;
      hs_hostack_reg <= 1'b0;
    end else begin
      unique case (seq_reg)
        ECPPR_IDLE: begin
          if (ob_take) begin
            tx_data_reg <= ob_q[0].data;
            tx_tag_reg <= ob_q[0].tag;
            hs_hostack_reg <= ob_q[0].tag; // address bytes flagged on autofeed
            seq_reg <= ECPPR_SETUP;
          end
        end
        ECPPR_SETUP: begin
          hs_strobe_reg <= 1'b1;
          hs_cnt_reg <= 2'(ecppr_pkg::HS_STROBE_CYCLES);
          seq_reg <= ECPPR_STROBE;
        end
        ECPPR_STROBE: begin
          if (hs_cnt_reg != 2'h0) begin
            hs_cnt_reg <= 2'(hs_cnt_reg - 1'b1);
          end else if (busy) begin
            // busy seen through the synchroniser, so never strobe again before it rose
            hs_strobe_reg <= 1'b0;
            seq_reg <= ECPPR_WAIT;
          end
        end
        ECPPR_WAIT: begin
          if (!busy) begin
            hs_hostack_reg <= 1'b0;
            seq_reg <= ECPPR_IDLE;
          end
        end
      endcase
    end
  end

  // service flag: test mode thresholds; set wins over a software clear
  logic [PW:0] free_cnt;
  logic svc_set;
  assign free_cnt = (PW+1)'((PW+1)'(DEPTH) - cnt_reg);
  assign svc_set = mode == ecppr_pkg::ECPPR_MODE_TEST &&
      (direction_in ? (cnt_reg >= (PW+1)'(ecppr_pkg::RX_FILL_THRESHOLD))
                    : (free_cnt >= (PW+1)'(ecppr_pkg::TX_SPACE_THRESHOLD)));
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      service_reg <= 1'b1;
    end else if (svc_set) begin
      service_reg <= 1'b1;
    end else if (wr_ext) begin
      service_reg <= wdata_reg[ecppr_pkg::EXT_SERVICE_BIT];
    end
  end

  // acknowledge interrupt: rising edge of acknowledge when enabled
  logic ack_d_reg, irq_reg;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ack_d_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      ack_d_reg <= ack_n;
      irq_reg <= ctl_reg[ecppr_pkg::CTL_ACK_IRQ] && ack_n && !ack_d_reg;
    end
  end
  assign IRQ_OUT = irq_reg;

  // read mux, latched at the falling read strobe
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (hit(ADDR_IN, ecppr_pkg::OFS_DATA,
            mode == ecppr_pkg::ECPPR_MODE_STANDARD || mode == ecppr_pkg::ECPPR_MODE_BIDIR)) begin
      rd_val = cab_reg;
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_STATUS, 1'b1)) begin
      rd_val = {!busy, ack_n, perr, sel, fault_n, 3'b000};
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_CONTROL, 1'b1)) begin
      rd_val = {2'b00, ctl_reg};
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_FIFO, fifo_mode)) begin
      rd_val = empty ? last_rd_reg : mem[rp_reg].data;
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_FIFO, mode == ecppr_pkg::ECPPR_MODE_CONFIG)) begin
      rd_val = ecppr_pkg::INFO_A_VALUE;
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_INFO_B, mode == ecppr_pkg::ECPPR_MODE_CONFIG)) begin
      rd_val = 8'h00;
      rd_val[ecppr_pkg::INFO_B_IRQ_BIT] = irq_reg;
    end else if (hit(ADDR_IN, ecppr_pkg::OFS_EXT_CTRL, 1'b1)) begin
      rd_val = {mode_reg, 1'b0, dma_reg, service_reg, full, empty};
    end
  end
  logic [7:0] hrd_reg;
  logic hoe_reg;
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      hrd_reg <= 8'h00;
      hoe_reg <= 1'b1;
    end else begin
      if (rd_start) begin
        hrd_reg <= rd_val;
        hoe_reg <= 1'b0;
      end else if (ior_n) begin
        hoe_reg <= 1'b1;
      end
    end
  end
  assign HOST_DATA_OUT = hrd_reg;
  assign HOST_DATA_OE_N_OUT = hoe_reg;

  // cable outputs
  logic auto_mode;
  assign auto_mode = fwd_mode || (mode == ecppr_pkg::ECPPR_MODE_ECP && direction_in);
  always_comb begin
    if (mode == ecppr_pkg::ECPPR_MODE_STANDARD || mode == ecppr_pkg::ECPPR_MODE_BIDIR) begin
      CABLE_DATA_LINES_OUT = data_reg;
    end else if (mode == ecppr_pkg::ECPPR_MODE_TEST) begin
      CABLE_DATA_LINES_OUT = last_rd_reg;
    end else begin
      CABLE_DATA_LINES_OUT = tx_data_reg;
    end
  end
  assign CABLE_DATA_LINES_OE_N_OUT = direction_in;
  assign STROBE_OUT_N_OUT = auto_mode ? !hs_strobe_reg : !ctl_reg[ecppr_pkg::CTL_STROBE];
  assign AUTOFEED_OUT_N_OUT = auto_mode ? !hs_hostack_reg
                                        : !ctl_reg[ecppr_pkg::CTL_AUTOFEED];
  assign INITIALIZE_OUT_N_OUT = ctl_reg[ecppr_pkg::CTL_INIT];
  assign SELECT_IN_OUT_N_OUT = !ctl_reg[ecppr_pkg::CTL_SELECT];
  assign ECP_MODE_OUT = mode == ecppr_pkg::ECPPR_MODE_ECP ||
                        (mode == ecppr_pkg::ECPPR_MODE_EPP && EPP_ENABLED_IN);
endmodule : ecppr_top
`default_nettype wire

// ---- tb/ecppr_chk.sv ----
// checker: port-level properties of the register bank
`timescale 1ns/1ps
`default_nettype none
module ecppr_chk (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic [10:0] ADDR_IN,
  input wire logic AEN_IN,
  input wire logic IO_READ_STROBE_N_IN,
  input wire logic [7:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE_N_OUT,
  input wire logic ACKNOWLEDGE_IN_N_IN,
  input wire logic STROBE_OUT_N_OUT,
  input wire logic AUTOFEED_OUT_N_OUT,
  input wire logic INITIALIZE_OUT_N_OUT,
  input wire logic SELECT_IN_OUT_N_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_rd_req;
    $fell(IO_READ_STROBE_N_IN) && !AEN_IN;
  endsequence
  sequence s_answer;
    $fell(HOST_DATA_OE_N_OUT);
  endsequence
  AST_RESET_OUTS: assert property (
    $rose(RSTN_IN) |-> STROBE_OUT_N_OUT && AUTOFEED_OUT_N_OUT && SELECT_IN_OUT_N_OUT
    && !INITIALIZE_OUT_N_OUT && !IRQ_OUT) else $error("outputs not at reset level");
  AST_READ_ANSWER: assert property (s_rd_req |-> ##[2:8] s_answer)
    else $error("read not answered in time");
  AST_ANSWER_CAUSE: assert property (s_answer |-> !$past(IO_READ_STROBE_N_IN, 2))
    else $error("data driven without a read");
  AST_READ_STANDS: assert property (
    !HOST_DATA_OE_N_OUT && !IO_READ_STROBE_N_IN |=> !HOST_DATA_OE_N_OUT)
    else $error("read data dropped early");
  AST_READ_RELEASE: assert property (
    $rose(IO_READ_STROBE_N_IN) |-> ##[1:8] HOST_DATA_OE_N_OUT) else $error("bus not released");
  AST_STATUS_LOW: assert property (
    $fell(HOST_DATA_OE_N_OUT) && ADDR_IN == ecppr_pkg::OFS_STATUS |-> HOST_DATA_OUT[2:0] == 3'h0)
    else $error("status low bits not zero");
  AST_CTRL_TOP_ZERO: assert property (
    $fell(HOST_DATA_OE_N_OUT) && ADDR_IN == ecppr_pkg::OFS_CONTROL |-> HOST_DATA_OUT[7:6] == 2'h0)
    else $error("control top bits not zero");
  AST_AEN_QUIET: assert property (AEN_IN && !HOST_DATA_OE_N_OUT |-> HOST_DATA_OUT == 8'h00)
    else $error("register answered during dma cycle");
  AST_IRQ_PULSE: assert property ($rose(IRQ_OUT) |=> !IRQ_OUT)
    else $error("irq longer than one cycle");
  AST_IRQ_CAUSE: assert property (
    $rose(IRQ_OUT) |-> ACKNOWLEDGE_IN_N_IN && !$past(ACKNOWLEDGE_IN_N_IN, 8))
    else $error("irq without acknowledge rise");
endmodule : ecppr_chk
`default_nettype wire

// ---- tb/ecppr_printer.sv ----
// partner: printer side, answers strobes with busy, acknowledge on request
`timescale 1ns/1ps
`default_nettype none
module ecppr_printer (
  input wire logic clk_in,
  input wire logic [7:0] drv_in,
  input wire logic drv_oe_n_in,
  input wire logic strobe_n_in,
  input wire logic slow_in,
  input wire logic force_busy_in,
  input wire logic ack_req_in,
  output logic [7:0] wire_out,
  output logic busy_out,
  output logic ack_n_out,
  output logic [15:0] got_out,
  output int got_cnt_out
);
  logic [7:0] last = 8'h00;
  logic prev_stb = 1'b1;
  logic busy_hs = 1'b0;
  int cnt = 0;
  int ack_cnt = 0;
  // released lines show the inverse, so a stale byte never reads back
  assign wire_out = drv_oe_n_in ? ~last : drv_in;
  assign busy_out = busy_hs | force_busy_in;
  assign ack_n_out = (ack_cnt == 0);
  initial got_out = 16'h0000;
  initial got_cnt_out = 0;
  always @(posedge clk_in) begin
    if (!drv_oe_n_in) last <= drv_in;
    prev_stb <= strobe_n_in;
    if (ack_req_in) ack_cnt <= 12;
    else if (ack_cnt != 0) ack_cnt <= ack_cnt - 1;
    if (prev_stb && !strobe_n_in) begin
      got_out <= {got_out[7:0], wire_out};
      got_cnt_out <= got_cnt_out + 1;
      busy_hs <= 1'b1;
      cnt <= 0;
    end else if (busy_hs && strobe_n_in) begin
      // slow answer keeps the port waiting on busy
      cnt <= cnt + 1;
      if (cnt == (slow_in ? 20 : 2)) busy_hs <= 1'b0;
    end
  end
endmodule : ecppr_printer
`default_nettype wire

// ---- tb/test_ecp_parallel_port_registers.sv ----
// testbench: scenario tasks for the register bank against the printer model
`timescale 1ns/1ps
`default_nettype none
module test_ecp_parallel_port_registers;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [10:0] addr = 11'h000;
  logic aen = 1'b0;
  logic ior_n = 1'b1;
  logic iow_n = 1'b1;
  logic [7:0] hdi = 8'h00;
  logic epp_en = 1'b1;
  logic fault_n = 1'b1;
  logic sel = 1'b0;
  logic perr = 1'b0;
  logic force_busy = 1'b0;
  logic slow = 1'b0;
  logic ack_req = 1'b0;
  logic [7:0] hdo, cdo, cdi, v;
  logic hoe_n, coe_n, stb_n, afd_n, init_n, selin_n, irq, ecpm, busy, ack_n;
  logic [15:0] got;
  int got_cnt, g0;
  int n_mismatch = 0;
  int compares = 0;
  always #2 clk = ~clk;
  ecppr_top i_dut (
    .CLOCK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .AEN_IN(aen),
    .IO_READ_STROBE_N_IN(ior_n), .IO_WRITE_STROBE_N_IN(iow_n), .HOST_DATA_IN(hdi),
    .HOST_DATA_OUT(hdo), .HOST_DATA_OE_N_OUT(hoe_n), .CABLE_DATA_LINES_IN(cdi),
    .CABLE_DATA_LINES_OUT(cdo), .CABLE_DATA_LINES_OE_N_OUT(coe_n), .FAULT_IN_N_IN(fault_n),
    .SELECT_IN(sel), .PAPER_ERROR_IN_IN(perr), .ACKNOWLEDGE_IN_N_IN(ack_n), .BUSY_IN(busy),
    .EPP_ENABLED_IN(epp_en), .STROBE_OUT_N_OUT(stb_n), .AUTOFEED_OUT_N_OUT(afd_n),
    .INITIALIZE_OUT_N_OUT(init_n), .SELECT_IN_OUT_N_OUT(selin_n), .IRQ_OUT(irq),
    .ECP_MODE_OUT(ecpm));
  ecppr_printer i_prn (
    .clk_in(clk), .drv_in(cdo), .drv_oe_n_in(coe_n), .strobe_n_in(stb_n), .slow_in(slow),
    .force_busy_in(force_busy), .ack_req_in(ack_req), .wire_out(cdi), .busy_out(busy),
    .ack_n_out(ack_n), .got_out(got), .got_cnt_out(got_cnt));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // strobes held six cycles each way (read strobe seven cycles low) so the input synchronisers see them
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic e = 1'b0);
    @(negedge clk);
    addr = a; hdi = d; aen = e; iow_n = 1'b0;
    repeat (6) @(negedge clk);
    iow_n = 1'b1;
    repeat (6) @(negedge clk);
    aen = 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d, input logic e = 1'b0);
    @(negedge clk);
    addr = a; aen = e; ior_n = 1'b0;
    repeat (7) @(negedge clk);
    d = (hoe_n === 1'b0) ? hdo : 8'h00;
    ior_n = 1'b1;
    repeat (6) @(negedge clk);
    aen = 1'b0;
  endtask : rd
  task automatic rc(input logic [10:0] a, input logic [7:0] e);
    rd(a, v);
    check(v, e);
  endtask : rc
  task automatic wait_got(input int n);
    int k = 0;
    while (got_cnt < n && k < 400) begin @(negedge clk); k++; end
    check(got_cnt[7:0], n[7:0]);
  endtask : wait_got
  task automatic t_basic;
    check({4'h0, stb_n, afd_n, init_n, selin_n}, 8'h0D);
    rc(ecppr_pkg::OFS_CONTROL, 8'h00);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'h05);
    rc(ecppr_pkg::OFS_DATA, 8'h00);
    wr(ecppr_pkg::OFS_CONTROL, 8'hFF);
    rc(ecppr_pkg::OFS_CONTROL, 8'h3F);
    check({4'h0, stb_n, afd_n, init_n, selin_n}, 8'h02);
    check({7'h00, coe_n}, 8'h00);
    wr(ecppr_pkg::OFS_CONTROL, 8'h00);
    wr(ecppr_pkg::OFS_DATA, 8'hA5);
    check(cdo, 8'hA5);
    rc(ecppr_pkg::OFS_DATA, 8'hA5);
    wr(ecppr_pkg::OFS_DATA, 8'h3C, 1'b1);
    check(cdo, 8'hA5);
    rd(ecppr_pkg::OFS_STATUS, v, 1'b1);
    check(v, 8'h00);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h24);
    wr(ecppr_pkg::OFS_CONTROL, 8'h20);
    check({7'h00, coe_n}, 8'h01);
    rc(ecppr_pkg::OFS_DATA, 8'h5A);
    wr(ecppr_pkg::OFS_CONTROL, 8'h00);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    for (int i = 0; i < 16; i++) begin
      {force_busy, perr, sel, fault_n} = i[3:0];
      rc(ecppr_pkg::OFS_STATUS, {~force_busy, 1'b1, perr, sel, fault_n, 3'h0});
    end
    {force_busy, perr, sel, fault_n} = 4'h1;
    $display("test basic done");
  endtask : t_basic
  task automatic t_irq;
    logic seen;
    for (int e = 1; e >= 0; e--) begin
      wr(ecppr_pkg::OFS_CONTROL, {3'h0, e[0], 4'h0});
      ack_req = 1'b1;
      @(negedge clk);
      ack_req = 1'b0;
      seen = 1'b0;
      repeat (40) begin @(negedge clk); seen |= irq; end
      check({7'h00, seen}, {7'h00, e[0]});
    end
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'hE4);
    rc(ecppr_pkg::OFS_FIFO, 8'h10);
    wr(ecppr_pkg::OFS_INFO_B, 8'hFF);
    rc(ecppr_pkg::OFS_INFO_B, 8'h00);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    $display("test irq done");
  endtask : t_irq
  task automatic t_modes;
    logic [2:0] m;
    for (int i = 0; i < 9; i++) begin
      m = (i == 8) ? 3'h4 : i[2:0];
      epp_en = (i < 8);
      wr(ecppr_pkg::OFS_EXT_CTRL, {m, 5'h04});
      check({7'h00, ecpm}, {7'h00, m == 3'h3 || (m == 3'h4 && epp_en)});
      rc(ecppr_pkg::OFS_EXT_CTRL, {m, 5'h05});
      wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_loopback_test_fifo;
    g0 = got_cnt;
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'hC4);
    wr(ecppr_pkg::OFS_FIFO, 8'h44);
    wr(ecppr_pkg::OFS_FIFO, 8'h33);
    wr(ecppr_pkg::OFS_FIFO, 8'h22);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'hC4);
    rc(ecppr_pkg::OFS_FIFO, 8'h44);
    rc(ecppr_pkg::OFS_FIFO, 8'h33);
    rc(ecppr_pkg::OFS_FIFO, 8'h22);
    rc(ecppr_pkg::OFS_FIFO, 8'h22);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'hC5);
    for (int i = 0; i <= ecppr_pkg::FIFO_DEPTH; i++) wr(ecppr_pkg::OFS_FIFO, i[7:0]);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'hC6);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'hC0);
    for (int i = 0; i < ecppr_pkg::FIFO_DEPTH; i++) begin
      rc(ecppr_pkg::OFS_FIFO, i[7:0]);
      rc(ecppr_pkg::OFS_EXT_CTRL, {3'h6, 2'h0, (i + 1) >= ecppr_pkg::TX_SPACE_THRESHOLD,
        1'b0, i == ecppr_pkg::FIFO_DEPTH - 1});
    end
    wr(ecppr_pkg::OFS_CONTROL, 8'h20);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      wr(ecppr_pkg::OFS_FIFO, i[7:0]);
      rc(ecppr_pkg::OFS_EXT_CTRL, {3'h6, 2'h0, (i + 1) >= ecppr_pkg::RX_FILL_THRESHOLD,
        2'h0});
    end
    rc(ecppr_pkg::OFS_FIFO, 8'h00);
    check(got_cnt[7:0], g0[7:0]);
    wr(ecppr_pkg::OFS_CONTROL, 8'h00);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'h05);
    $display("test fifo done");
  endtask : t_loopback_test_fifo
  task automatic t_auto;
    g0 = got_cnt;
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h44);
    wr(ecppr_pkg::OFS_FIFO, 8'h96);
    wr(ecppr_pkg::OFS_FIFO, 8'h69);
    wait_got(g0 + 2);
    check(got[15:8], 8'h96);
    check(got[7:0], 8'h69);
    rc(ecppr_pkg::OFS_EXT_CTRL, 8'h45);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    slow = 1'b1;
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h64);
    wr(ecppr_pkg::OFS_FIFO, 8'h3C);
    wr(ecppr_pkg::OFS_DATA, 8'h81);
    wait_got(g0 + 4);
    check(got[15:8], 8'h3C);
    check(got[7:0], 8'h81);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    slow = 1'b0;
    wr(ecppr_pkg::OFS_CONTROL, 8'h20);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h64);
    check({7'h00, afd_n}, 8'h00);
    ack_req = 1'b1;
    @(negedge clk);
    ack_req = 1'b0;
    repeat (30) @(negedge clk);
    rc(ecppr_pkg::OFS_FIFO, 8'h5A);
    wr(ecppr_pkg::OFS_CONTROL, 8'h00);
    wr(ecppr_pkg::OFS_EXT_CTRL, 8'h04);
    $display("test auto done");
  endtask : t_auto
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    // whole run is about 2400 cycles; allow about four times that
    #40000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    t_basic;
    t_irq;
    t_modes;
    t_loopback_test_fifo;
    t_auto;
    tally_and_finish;
  end
endmodule : test_ecp_parallel_port_registers
bind ecppr_top ecppr_chk i_chk (
  .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .AEN_IN(AEN_IN),
  .IO_READ_STROBE_N_IN(IO_READ_STROBE_N_IN), .HOST_DATA_OUT(HOST_DATA_OUT),
  .HOST_DATA_OE_N_OUT(HOST_DATA_OE_N_OUT), .ACKNOWLEDGE_IN_N_IN(ACKNOWLEDGE_IN_N_IN),
  .STROBE_OUT_N_OUT(STROBE_OUT_N_OUT), .AUTOFEED_OUT_N_OUT(AUTOFEED_OUT_N_OUT),
  .INITIALIZE_OUT_N_OUT(INITIALIZE_OUT_N_OUT), .SELECT_IN_OUT_N_OUT(SELECT_IN_OUT_N_OUT),
  .IRQ_OUT(IRQ_OUT));
`default_nettype wire
